// *** plc_defines.svh ***
/*
  Constants of the closed-loop process controller: timing, scaling, selector codes,
  register offsets and reset values. Assumes a 125 MHz clock and values in 0.01 % steps.
*/
//////////////////////////////////////////////////////////////////////////////
`ifndef PLC_DEFINES_SVH
`define PLC_DEFINES_SVH

// timing
`define PLC_CLK_MHZ 125
`define PLC_TICK_US 1000
`define PLC_TICK_CYCLES (`PLC_TICK_US * `PLC_CLK_MHZ)
`define PLC_GATE_MS 100
`define PLC_GATE_CYCLES (`PLC_GATE_MS * 1000 * `PLC_CLK_MHZ)

// scaling: 10000 counts are 100.00 %
`define PLC_FULL_SCALE 10000
`define PLC_VAL_MAX 32767
`define PLC_PULSE_MAX_HZ 32000
`define PLC_PULSE_FULL_CNT (`PLC_PULSE_MAX_HZ * `PLC_GATE_MS / 1000)
`define PLC_GAIN_DIV 1000000
`define PLC_ITIME_TICKS 100

// source selector codes
`define PLC_SRC_KEYPAD 8'h00
`define PLC_SRC_VOLTAGE 8'h01
`define PLC_SRC_SERIAL 8'h05
`define PLC_SRC_OPTION 8'h07
`define PLC_SRC_USERSEQ 8'h09
`define PLC_SRC_PULSE 8'h0b

// monitor and terminal function codes
`define PLC_MON_REF 8'h11
`define PLC_MON_FBK 8'h12
`define PLC_MF_ICLEAR 8'h15
`define PLC_MF_COUNT 7

// register byte offsets
`define PLC_OFS_CTRL 12'h000
`define PLC_OFS_REF_SRC 12'h004
`define PLC_OFS_FBK_SRC 12'h008
`define PLC_OFS_SETPOINT 12'h00c
`define PLC_OFS_PGAIN 12'h010
`define PLC_OFS_PSCALE 12'h014
`define PLC_OFS_ITIME 12'h018
`define PLC_OFS_DTIME 12'h01c
`define PLC_OFS_MON_SEL 12'h020
`define PLC_OFS_MF_FUNC0 12'h024
`define PLC_OFS_MF_FUNC1 12'h028
`define PLC_OFS_REF_MON 12'h02c
`define PLC_OFS_FBK_MON 12'h030
`define PLC_OFS_OUT 12'h034
`define PLC_OFS_STATUS 12'h038

// reset values
`define PLC_RST_CTRL 1'h1
`define PLC_RST_REF_SRC 8'h00
`define PLC_RST_FBK_SRC 8'h01
`define PLC_RST_PGAIN 14'h01f4
`define PLC_RST_PSCALE 10'h3e8
`define PLC_RST_ITIME 16'h0064
`define PLC_RST_DTIME 16'h0000

`endif

// *** plc_pkg.sv ***
/*
  Types shared by the controller files. Assumes plc_defines.svh for all figures.
*/
package plc_pkg;

  typedef logic signed [15:0] plc_val_t;

  typedef enum logic [2:0] {
    PLC_ST_IDLE  = 3'b001,
    PLC_ST_TERMS = 3'b010,
    PLC_ST_SUM   = 3'b100
  } plc_state_t;

endpackage

// *** plc_pulse_meter.sv ***
/*
  Pulse input frequency meter: counts rising edges over a fixed gate and scales
  the count so that the top input frequency reads as full scale.
  Assumes the pulse pin is already synchronous to clk_i.
*/
`timescale 1ns/100ps
`include "plc_defines.svh"

module plc_pulse_meter #(
  parameter int GATE_CYCLES = `PLC_GATE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // pulse pin
  input wire logic pulse_i,
  // scaled frequency, 0.01 % steps
  output logic signed [15:0] value_o
);

  logic pulse_q;
  logic [31:0] gate_q;
  logic [15:0] count_q;
  logic [31:0] scaled_w;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulse_q <= 1'b0;
    end else begin
      pulse_q <= pulse_i;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gate_q <= 32'h0;
    end else if (gate_q == 32'(GATE_CYCLES - 1)) begin
      gate_q <= 32'h0;
    end else begin
      gate_q <= gate_q + 32'h1;
    end
  end

  // above the top frequency the reading is held at full scale
  assign scaled_w = 32'(count_q) * 32'(`PLC_FULL_SCALE) / 32'(`PLC_PULSE_FULL_CNT);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count_q <= 16'h0;
      value_o <= 16'sh0;
    end else if (gate_q == 32'(GATE_CYCLES - 1)) begin
      count_q <= 16'h0;
      value_o <= (count_q >= 16'(`PLC_PULSE_FULL_CNT)) ? 16'(`PLC_FULL_SCALE) : scaled_w[15:0];
    end else if (pulse_i && !pulse_q && count_q != 16'hffff) begin
      count_q <= count_q + 16'h1;
    end
  end

endmodule

// *** plc_sat_add.sv ***
/*
  Signed adder that clamps to the output width instead of wrapping.
  Assumes both operands are already sign extended to IW bits.
*/
`timescale 1ns/100ps

module plc_sat_add #(
  parameter int IW = 16,
  parameter int OW = 16
) (
  // operands
  input wire logic signed [IW-1:0] a_i,
  input wire logic signed [IW-1:0] b_i,
  // clamped sum
  output logic signed [OW-1:0] sum_o
);

  logic signed [IW:0] sum_w;
  logic signed [IW:0] max_w;
  logic signed [IW:0] min_w;

  assign sum_w = {a_i[IW-1], a_i} + {b_i[IW-1], b_i};
  assign max_w = (IW+1)'({1'b0, {(OW-1){1'b1}}});
  assign min_w = -max_w - (IW+1)'(1);

  always_comb begin
    if (sum_w > max_w) begin
      sum_o = max_w[OW-1:0];
    end else if (sum_w < min_w) begin
      sum_o = min_w[OW-1:0];
    end else begin
      sum_o = sum_w[OW-1:0];
    end
  end

endmodule

// *** plc_source_model.sv ***
/*
  Process source model: holds the four level sources and makes the pulse train.
  Assumes the bench supplies the level values and runs it on the controller clock.
*/
`timescale 1ns/100ps

module plc_source_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // values asked for by the bench
  input wire logic signed [15:0] lvl_i [4],
  // source pins
  output logic signed [15:0] volt_o,
  output logic signed [15:0] serial_o,
  output logic signed [15:0] option_o,
  output logic signed [15:0] useq_o,
  output logic pulse_o
);
  logic [2:0] ph_q;

  assign volt_o = lvl_i[0];
  assign serial_o = lvl_i[1];
  assign option_o = lvl_i[2];
  assign useq_o = lvl_i[3];
  // period 8 divides the shortened gate, so every gate holds exactly 25 edges
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) ph_q <= 3'h0;
    else ph_q <= ph_q + 3'h1;
  end
  assign pulse_o = ph_q[2];
endmodule

// *** plc_top.sv ***
/*
  Closed-loop process controller with an APB register slave. Selects a reference and
  a feedback source, forms the error and adds proportional, integral and derivative
  terms once per control tick. Assumes all source inputs are synchronous to clk_i
  and carry signed values where 10000 counts are 100.00 %.
*/
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "plc_defines.svh"

module plc_top #(
  parameter int TICK_CYCLES = `PLC_TICK_CYCLES,
  parameter int GATE_CYCLES = `PLC_GATE_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // apb slave
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // process sources
  input wire logic signed [15:0] bipolar_voltage_input_i,
  input wire logic signed [15:0] serial_value_i,
  input wire logic signed [15:0] option_card_command_i,
  input wire logic signed [15:0] user_sequence_link_i,
  input wire logic pulse_input_pin_i,
  // multi-function terminals
  input wire logic [`PLC_MF_COUNT-1:0] mf_terminal_i,
  // frequency command path and monitors
  output logic signed [15:0] pid_output_o,
  output logic pid_output_valid_o,
  output logic signed [15:0] monitor_a_o,
  output logic signed [15:0] monitor_b_o
);

  //////////////////////////////////////////////////////////////////////////////
  // registers

  logic enable_q;
  logic [7:0] ref_src_q;
  logic [7:0] fbk_src_q;
  logic signed [15:0] keypad_setpoint_q;
  logic [13:0] pgain_q;
  logic [9:0] pscale_q;
  logic [15:0] itime_q;
  logic [15:0] dtime_q;
  logic [7:0] mon_a_sel_q;
  logic [7:0] mon_b_sel_q;
  logic [7:0] mf_func_q [`PLC_MF_COUNT];
  logic reject_q;
  logic isat_q;

  logic [31:0] prdata_d;
  logic slverr_d;
  logic wr_w;
  logic setup_w;
  logic [31:0] wval_w;
  logic src_ok_w;

  //////////////////////////////////////////////////////////////////////////////
  // datapath signals

  plc_pkg::plc_state_t state_q;
  logic [31:0] tick_cnt_q;
  logic tick_w;
  plc_pkg::plc_val_t pulse_val_w;
  plc_pkg::plc_val_t ref_w;
  plc_pkg::plc_val_t fbk_w;
  plc_pkg::plc_val_t ref_q;
  plc_pkg::plc_val_t fbk_q;
  plc_pkg::plc_val_t err_w;
  plc_pkg::plc_val_t err_q;
  plc_pkg::plc_val_t err_prev_q;
  logic have_prev_q;
  plc_pkg::plc_val_t p_q;
  plc_pkg::plc_val_t d_q;
  plc_pkg::plc_val_t i_w;
  plc_pkg::plc_val_t pi_w;
  plc_pkg::plc_val_t pid_w;
  logic signed [47:0] acc_q;
  logic signed [47:0] acc_sum_w;
  logic signed [47:0] acc_lim_w;
  logic signed [47:0] it_ticks_w;
  logic signed [47:0] p_wide_w;
  logic signed [47:0] d_wide_w;
  logic iclear_w;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic plc_pkg::plc_val_t sat16(input logic signed [47:0] v);
    if (v > 48'sd32767) begin
      sat16 = 16'sh7fff;
    end else if (v < -48'sd32768) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    merge = r;
  endfunction

  function automatic logic code_known(input logic [7:0] c);
    code_known = (c == `PLC_SRC_KEYPAD) || (c == `PLC_SRC_VOLTAGE) || (c == `PLC_SRC_SERIAL) ||
                 (c == `PLC_SRC_OPTION) || (c == `PLC_SRC_USERSEQ) || (c == `PLC_SRC_PULSE);
  endfunction

  function automatic plc_pkg::plc_val_t src_value(input logic [7:0] c);
    case (c)
      `PLC_SRC_KEYPAD: src_value = keypad_setpoint_q;
      `PLC_SRC_VOLTAGE: src_value = bipolar_voltage_input_i;
      `PLC_SRC_SERIAL: src_value = serial_value_i;
      `PLC_SRC_OPTION: src_value = option_card_command_i;
      `PLC_SRC_USERSEQ: src_value = user_sequence_link_i;
      `PLC_SRC_PULSE: src_value = pulse_val_w;
      default: src_value = 16'sh0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // apb access

  // zero wait states: read data is registered in the setup cycle
  assign pready_o = 1'b1;
  assign setup_w = psel_i && !penable_i;
  assign wr_w = psel_i && penable_i && pwrite_i;
  assign wval_w = merge(32'h0, pwdata_i, pstrb_i);

  // a selector write must name a known code; feedback may not be keypad or the reference
  always_comb begin
    src_ok_w = 1'b1;
    if (paddr_i == `PLC_OFS_REF_SRC) begin
      src_ok_w = code_known(wval_w[7:0]) && (wval_w[7:0] != fbk_src_q);
    end else if (paddr_i == `PLC_OFS_FBK_SRC) begin
      src_ok_w = code_known(wval_w[7:0]) && (wval_w[7:0] != `PLC_SRC_KEYPAD) &&
                 (wval_w[7:0] != ref_src_q);
    end
  end

  always_comb begin
    prdata_d = 32'h0;
    slverr_d = 1'b0;
    case (paddr_i)
      `PLC_OFS_CTRL: prdata_d = {31'h0, enable_q};
      `PLC_OFS_REF_SRC: prdata_d = {24'h0, ref_src_q};
      `PLC_OFS_FBK_SRC: prdata_d = {24'h0, fbk_src_q};
      `PLC_OFS_SETPOINT: prdata_d = {16'h0, keypad_setpoint_q};
      `PLC_OFS_PGAIN: prdata_d = {18'h0, pgain_q};
      `PLC_OFS_PSCALE: prdata_d = {22'h0, pscale_q};
      `PLC_OFS_ITIME: prdata_d = {16'h0, itime_q};
      `PLC_OFS_DTIME: prdata_d = {16'h0, dtime_q};
      `PLC_OFS_MON_SEL: prdata_d = {16'h0, mon_b_sel_q, mon_a_sel_q};
      `PLC_OFS_MF_FUNC0: prdata_d = {mf_func_q[3], mf_func_q[2], mf_func_q[1], mf_func_q[0]};
      `PLC_OFS_MF_FUNC1: prdata_d = {8'h0, mf_func_q[6], mf_func_q[5], mf_func_q[4]};
      `PLC_OFS_REF_MON: prdata_d = {16'h0, ref_q};
      `PLC_OFS_FBK_MON: prdata_d = {16'h0, fbk_q};
      `PLC_OFS_OUT: prdata_d = {16'h0, pid_output_o};
      `PLC_OFS_STATUS: prdata_d = {29'h0, isat_q, reject_q, iclear_w};
      default: slverr_d = 1'b1;
    endcase
    if (pwrite_i) begin
      prdata_d = 32'h0;
      slverr_d = slverr_d || !src_ok_w;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (setup_w) begin
      prdata_o <= prdata_d;
      pslverr_o <= slverr_d;
    end
  end

  // writes to read-only offsets and refused selector codes leave the registers untouched
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      enable_q <= `PLC_RST_CTRL;
      ref_src_q <= `PLC_RST_REF_SRC;
      fbk_src_q <= `PLC_RST_FBK_SRC;
      keypad_setpoint_q <= 16'sh0;
      pgain_q <= `PLC_RST_PGAIN;
      pscale_q <= `PLC_RST_PSCALE;
      itime_q <= `PLC_RST_ITIME;
      dtime_q <= `PLC_RST_DTIME;
      mon_a_sel_q <= 8'h0;
      mon_b_sel_q <= 8'h0;
      for (int t = 0; t < `PLC_MF_COUNT; t++) begin
        mf_func_q[t] <= 8'h0;
      end
    end else if (wr_w) begin
      case (paddr_i)
        `PLC_OFS_CTRL: enable_q <= merge({31'h0, enable_q}, pwdata_i, pstrb_i) != 32'h0;
        `PLC_OFS_REF_SRC: if (src_ok_w && pstrb_i[0]) ref_src_q <= pwdata_i[7:0];
        `PLC_OFS_FBK_SRC: if (src_ok_w && pstrb_i[0]) fbk_src_q <= pwdata_i[7:0];
        `PLC_OFS_SETPOINT: keypad_setpoint_q <= 16'(merge({16'h0, keypad_setpoint_q}, pwdata_i, pstrb_i));
        `PLC_OFS_PGAIN: begin
          // gain above 1000.0 % is clamped
          if (merge({18'h0, pgain_q}, pwdata_i, pstrb_i) > 32'(`PLC_FULL_SCALE)) begin
            pgain_q <= 14'(`PLC_FULL_SCALE);
          end else begin
            pgain_q <= 14'(merge({18'h0, pgain_q}, pwdata_i, pstrb_i));
          end
        end
        `PLC_OFS_PSCALE: pscale_q <= 10'(merge({22'h0, pscale_q}, pwdata_i, pstrb_i));
        `PLC_OFS_ITIME: itime_q <= 16'(merge({16'h0, itime_q}, pwdata_i, pstrb_i));
        `PLC_OFS_DTIME: dtime_q <= 16'(merge({16'h0, dtime_q}, pwdata_i, pstrb_i));
        `PLC_OFS_MON_SEL: begin
          if (pstrb_i[0]) mon_a_sel_q <= pwdata_i[7:0];
          if (pstrb_i[1]) mon_b_sel_q <= pwdata_i[15:8];
        end
        `PLC_OFS_MF_FUNC0: begin
          for (int b = 0; b < 4; b++) begin
            if (pstrb_i[b]) mf_func_q[b] <= pwdata_i[b*8 +: 8];
          end
        end
        `PLC_OFS_MF_FUNC1: begin
          for (int b = 0; b < 3; b++) begin
            if (pstrb_i[b]) mf_func_q[b+4] <= pwdata_i[b*8 +: 8];
          end
        end
        default: ;
      endcase
    end
  end

  // sticky until the next accepted selector write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reject_q <= 1'b0;
    end else if (wr_w && (paddr_i == `PLC_OFS_REF_SRC || paddr_i == `PLC_OFS_FBK_SRC)) begin
      reject_q <= !src_ok_w;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // sources and control tick

  plc_pulse_meter #(
    .GATE_CYCLES(GATE_CYCLES)
  ) u_pulse (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pulse_i(pulse_input_pin_i),
    .value_o(pulse_val_w)
  );

  assign ref_w = src_value(ref_src_q);
  assign fbk_w = (fbk_src_q == `PLC_SRC_KEYPAD) ? 16'sh0 : src_value(fbk_src_q);

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_q <= 32'h0;
    end else if (tick_w) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  assign tick_w = (tick_cnt_q == 32'(TICK_CYCLES - 1));

  always_comb begin
    iclear_w = 1'b0;
    for (int t = 0; t < `PLC_MF_COUNT; t++) begin
      iclear_w = iclear_w || (mf_terminal_i[t] && mf_func_q[t] == `PLC_MF_ICLEAR);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // loop arithmetic

  plc_sat_add #(
    .IW(17),
    .OW(16)
  ) u_err (
    .a_i({ref_w[15], ref_w}),
    .b_i(-{fbk_w[15], fbk_w}),
    .sum_o(err_w)
  );

  // gain and scale are both in 0.1 % steps, so their product divides by a million
  assign p_wide_w = 48'(err_q) * $signed({34'h0, pgain_q}) * $signed({38'h0, pscale_q});
  // derivative time in ms times the error change over one 1 ms tick
  assign d_wide_w = (48'(err_q) - 48'(err_prev_q)) * $signed({32'h0, dtime_q});
  // integral time is in 0.1 s steps, each worth this many ticks
  assign it_ticks_w = $signed({32'h0, itime_q}) * 48'(`PLC_ITIME_TICKS);
  assign acc_lim_w = it_ticks_w * 48'(`PLC_VAL_MAX);
  assign acc_sum_w = acc_q + 48'(err_q);
  assign i_w = (itime_q == 16'h0) ? 16'sh0 : sat16(acc_q / it_ticks_w);

  plc_sat_add #(
    .IW(16),
    .OW(16)
  ) u_sum_pi (
    .a_i(p_q),
    .b_i(i_w),
    .sum_o(pi_w)
  );

  plc_sat_add #(
    .IW(16),
    .OW(16)
  ) u_sum_pid (
    .a_i(pi_w),
    .b_i(d_q),
    .sum_o(pid_w)
  );

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= plc_pkg::PLC_ST_IDLE;
    end else begin
      case (state_q)
        plc_pkg::PLC_ST_IDLE: if (tick_w && enable_q) state_q <= plc_pkg::PLC_ST_TERMS;
        plc_pkg::PLC_ST_TERMS: state_q <= plc_pkg::PLC_ST_SUM;
        plc_pkg::PLC_ST_SUM: state_q <= plc_pkg::PLC_ST_IDLE;
        default: state_q <= plc_pkg::PLC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ref_q <= 16'sh0;
      fbk_q <= 16'sh0;
      err_q <= 16'sh0;
    end else if (state_q == plc_pkg::PLC_ST_IDLE && tick_w && enable_q) begin
      ref_q <= ref_w;
      fbk_q <= fbk_w;
      err_q <= err_w;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      p_q <= 16'sh0;
      d_q <= 16'sh0;
      err_prev_q <= 16'sh0;
      have_prev_q <= 1'b0;
    end else if (!enable_q) begin
      have_prev_q <= 1'b0;
    end else if (state_q == plc_pkg::PLC_ST_TERMS) begin
      p_q <= sat16(p_wide_w / 48'(`PLC_GAIN_DIV));
      // no slope is known on the first update, so no derivative kick
      d_q <= have_prev_q ? sat16(d_wide_w) : 16'sh0;
      err_prev_q <= err_q;
      have_prev_q <= 1'b1;
    end
  end

  // anti-windup: the accumulator stops where the integral term would clip
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q <= 48'sh0;
      isat_q <= 1'b0;
    end else if (iclear_w || !enable_q || itime_q == 16'h0) begin
      acc_q <= 48'sh0;
      isat_q <= 1'b0;
    end else if (state_q == plc_pkg::PLC_ST_TERMS) begin
      if (acc_sum_w > acc_lim_w) begin
        acc_q <= acc_lim_w;
        isat_q <= 1'b1;
      end else if (acc_sum_w < -acc_lim_w) begin
        acc_q <= -acc_lim_w;
        isat_q <= 1'b1;
      end else begin
        acc_q <= acc_sum_w;
        isat_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pid_output_o <= 16'sh0;
      pid_output_valid_o <= 1'b0;
    end else begin
      pid_output_valid_o <= (state_q == plc_pkg::PLC_ST_SUM);
      if (!enable_q) begin
        pid_output_o <= 16'sh0;
      end else if (state_q == plc_pkg::PLC_ST_SUM) begin
        pid_output_o <= pid_w;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // monitors

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      monitor_a_o <= 16'sh0;
      monitor_b_o <= 16'sh0;
    end else begin
      monitor_a_o <= (mon_a_sel_q == `PLC_MON_REF) ? ref_q :
                     (mon_a_sel_q == `PLC_MON_FBK) ? fbk_q : 16'sh0;
      monitor_b_o <= (mon_b_sel_q == `PLC_MON_REF) ? ref_q :
                     (mon_b_sel_q == `PLC_MON_FBK) ? fbk_q : 16'sh0;
    end
  end

endmodule

// *** plc_top_checker.sv ***
/*
  Port checker for the controller. Assumes enable stays set and the shortened tick.
*/
`timescale 1ns/100ps
`include "plc_defines.svh"

module plc_top_checker #(parameter int TICK_CYCLES = 20) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [11:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic signed [15:0] pid_output_o,
  input wire logic pid_output_valid_o
);
  logic [31:0] gap_q;
  logic seen_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gap_q <= 32'h0;
      seen_q <= 1'b0;
    end else if (pid_output_valid_o) begin
      gap_q <= 32'h0;
      seen_q <= 1'b1;
    end else gap_q <= gap_q + 32'h1;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  tick_period_a: assert property (pid_output_valid_o && seen_q |-> gap_q == TICK_CYCLES - 1)
    else $error("update spacing differs from tick");
  valid_single_a: assert property (pid_output_valid_o |=> !pid_output_valid_o [*8])
    else $error("valid longer than one cycle");
  hold_between_a: assert property (!pid_output_valid_o |-> $stable(pid_output_o))
    else $error("output moved without valid");
  reset_idle_a: assert property ($rose(arst_n_i) |-> pid_output_o == 16'sh0 && !pid_output_valid_o)
    else $error("output not idle after reset");
  ready_high_a: assert property (pready_o)
    else $error("ready low");
  write_rdata_a: assert property (psel_i && penable_i && pwrite_i |-> prdata_o == 32'h0)
    else $error("read data not zero in write");
  unmapped_err_a: assert property (psel_i && !penable_i && paddr_i > 12'h038 |=> pslverr_o)
    else $error("no error for unmapped offset");
  mapped_read_a: assert property (psel_i && !penable_i && !pwrite_i && paddr_i <= 12'h038 && paddr_i[1:0] == 2'h0
    |=> !pslverr_o)
    else $error("error on mapped read");
endmodule

bind plc_top plc_top_checker #(.TICK_CYCLES(TICK_CYCLES)) i_plc_top_checker (.clk_i(clk_i), .arst_n_i(arst_n_i),
  .paddr_i(paddr_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pid_output_o(pid_output_o), .pid_output_valid_o(pid_output_valid_o));

// *** testbench.sv ***
/*
  Self-checking bench for the controller. Assumes the shortened tick (20) and gate (200).
*/
`timescale 1ns/100ps

module testbench;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [6:0] mf = 0;
  logic signed [15:0] lvl [4], sp, o1, v, p, mon_a, mon_b;
  wire logic signed [15:0] s0, s1, s2, s3;
  wire logic pin, prdy, perr, vld;
  wire logic [31:0] prdata;
  int fail_count = 0, cmp_count = 0, n;
  logic [31:0] ra [7] = '{32'h0, 32'h4, 32'h8, 32'h10, 32'h14, 32'h18, 32'h1c};
  logic [31:0] rv [7] = '{32'h1, 32'h0, 32'h1, 32'h1f4, 32'h3e8, 32'h64, 32'h0};
  logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h05, 8'h07, 8'h09};
  logic [31:0] gn [4] = '{32'd500, 32'd10000, 32'd20000, 32'd10000};
  logic [31:0] sc [4] = '{32'd1000, 32'd1000, 32'd1000, 32'd1};
  logic signed [15:0] pe [4] = '{16'sd100, 16'sd2000, 16'sd2000, 16'sd2};

  initial forever #4 clk = ~clk;
  plc_source_model i_plc_source_model (.clk_i(clk), .arst_n_i(rst_n), .lvl_i(lvl), .volt_o(s0), .serial_o(s1),
    .option_o(s2), .useq_o(s3), .pulse_o(pin));
  plc_top #(.TICK_CYCLES(20), .GATE_CYCLES(200)) i_plc_top (.clk_i(clk), .arst_n_i(rst_n), .paddr_i(paddr),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(4'hf), .prdata_o(prdata),
    .pready_o(prdy), .pslverr_o(perr), .bipolar_voltage_input_i(s0), .serial_value_i(s1),
    .option_card_command_i(s2), .user_sequence_link_i(s3), .pulse_input_pin_i(pin), .mf_terminal_i(mf),
    .pid_output_o(p), .pid_output_valid_o(vld), .monitor_a_o(mon_a), .monitor_b_o(mon_b));

  // 25 edges a gate, scaled so 3200 edges read full scale
  function automatic logic signed [15:0] exp_src(input logic [7:0] c);
    case (c)
      8'h00: return sp;
      8'h01: return lvl[0];
      8'h05: return lvl[1];
      8'h07: return lvl[2];
      8'h09: return lvl[3];
      default: return 16'(25 * 10000 / 3200);
    endcase
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1;
    penable <= 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    mf[6:1] <= 6'($urandom);
    @(posedge clk);
    penable <= 1;
    n = 0;
    do @(posedge clk); while (prdy !== 1'b1 && ++n < 50);
    if (n >= 50) begin
      fail_count++;
      end_sim();
    end
    rd = prdata;
    err = perr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task automatic wv(input int k);
    repeat (k) begin
      n = 0;
      do @(negedge clk); while (vld !== 1'b1 && ++n < 100);
      if (n >= 100) begin
        fail_count++;
        end_sim();
      end
    end
    @(posedge clk);
  endtask

  initial begin
    void'($urandom(29));
    foreach (lvl[i]) lvl[i] = 16'($urandom_range(40000)) - 16'sd20000;
    repeat (16) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    foreach (ra[i]) begin
      apb(ra[i][11:0], 0, 0);
      chk("reset value", rd, rv[i]);
    end
    apb(12'h040, 0, 0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    $display("test reset done");
    sp = 16'($urandom_range(4000)) * 16'sd2;
    apb(12'h008, 1, 32'h0b);
    apb(12'h00c, 1, 32'(sp));
    repeat (450) @(posedge clk);
    apb(12'h030, 0, 0);
    chk("pulse feedback", rd, {16'h0, exp_src(8'h0b)});
    foreach (codes[i]) begin
      apb(12'h004, 1, 32'(codes[i]));
      wv(2);
      apb(12'h02c, 0, 0);
      chk("reference", rd, {16'h0, exp_src(codes[i])});
    end
    $display("test sources done");
    apb(12'h008, 1, 32'h09);
    chk("same source refused", {31'h0, err}, 32'h1);
    apb(12'h008, 1, 32'h00);
    chk("keypad feedback refused", {31'h0, err}, 32'h1);
    apb(12'h004, 1, 32'h0b);
    chk("ref equal feedback refused", {31'h0, err}, 32'h1);
    apb(12'h008, 0, 0);
    chk("feedback kept", rd, 32'h0b);
    apb(12'h038, 0, 0);
    chk("refused flag", {31'h0, rd[1]}, 32'h1);
    apb(12'h020, 1, 32'h1211);
    wv(2);
    chk("monitor ref", 32'(mon_a), 32'(exp_src(8'h09)));
    chk("monitor fbk", 32'(mon_b), 32'(exp_src(8'h0b)));
    $display("test refusal monitor done");
    apb(12'h004, 1, 32'h00);
    apb(12'h018, 1, 32'h0);
    sp = exp_src(8'h0b) + 16'sd200;
    apb(12'h00c, 1, 32'(sp));
    foreach (gn[i]) begin
      apb(12'h010, 1, gn[i]);
      apb(12'h014, 1, sc[i]);
      wv(2);
      chk("proportional", 32'(p), 32'(pe[i]));
    end
    apb(12'h010, 1, 32'h0);
    apb(12'h01c, 1, 32'h3);
    wv(2);
    sp = sp + 16'sd10;
    apb(12'h00c, 1, 32'(sp));
    wv(1);
    chk("derivative step", 32'(p), 32'sd30);
    wv(1);
    chk("derivative settled", 32'(p), 32'h0);
    $display("test gain done");
    apb(12'h01c, 1, 32'h0);
    apb(12'h024, 1, 32'h15);
    mf[0] <= 1;
    apb(12'h018, 1, 32'h1);
    sp = exp_src(8'h0b) + 16'sd10000;
    apb(12'h00c, 1, 32'(sp));
    wv(3);
    chk("integral cleared", 32'(p), 32'h0);
    mf[0] <= 0;
    wv(3);
    o1 = p;
    wv(1);
    v = p - o1;
    chk("integral rate", 32'(v), 32'sd100);
    apb(12'h010, 1, 32'd10000);
    apb(12'h014, 1, 32'd1023);
    apb(12'h00c, 1, 32'h7fff);
    wv(2);
    chk("saturated output", 32'(p), 32'sd32767);
    $display("test integral done");
    end_sim();
  end
endmodule
